// ---- inc/spi_cmd_pkg.sv ----
package spi_cmd_pkg;

  // ----------------------------------------------------------------
  // command byte layout
  // ----------------------------------------------------------------
  localparam int CMD_BITS = 8;
  localparam logic [3:0] CMD_LAST_BIT = 4'h7;
  localparam logic [3:0] CMD_DONE = 4'h8;
  localparam logic [3:0] ADDR_DONE = 4'h1;
  localparam logic [3:0] STAT_LATCH = 4'h2;

  typedef enum logic [1:0] {
    CT_QUICK = 2'b00,
    CT_STATIC_READ = 2'b01,
    CT_INCR_WRITE = 2'b10,
    CT_INCR_READ = 2'b11
  } cmd_type_t;

  typedef struct packed {
    logic [1:0] dev_addr;
    logic [3:0] reg_addr;
    cmd_type_t ctype;
  } cmd_t;

  // ----------------------------------------------------------------
  // hard-wired device address
  // ----------------------------------------------------------------
  localparam logic [1:0] DEV_ADDR = 2'h1;

  // ----------------------------------------------------------------
  // quick command codes
  // ----------------------------------------------------------------
  localparam logic [3:0] QC_CONV_START = 4'ha;
  localparam logic [3:0] QC_STANDBY = 4'hb;
  localparam logic [3:0] QC_SHUTDOWN = 4'hc;
  localparam logic [3:0] QC_FULL_SHUTDOWN = 4'hd;
  localparam logic [3:0] QC_FULL_RESET = 4'he;

  // ----------------------------------------------------------------
  // first configuration register
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG0_RESET = 8'h10;
  localparam logic [7:0] CFG0_FULL_SHUTDOWN = 8'h00;
  localparam int MODE_LSB = 0;
  localparam logic [1:0] MODE_CONVERT = 2'h3;
  localparam logic [1:0] MODE_STANDBY = 2'h2;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;

  // read-only register addresses, one bit per address
  localparam logic [15:0] READ_ONLY_MASK = 16'h8001;

  // ----------------------------------------------------------------
  // status and decoded access
  // ----------------------------------------------------------------
  typedef struct packed {
    logic data_ready;
    logic crc_error;
    logic power_on;
  } status_t;

  typedef struct packed {
    logic valid;
    logic read;
    logic incremental;
    logic [3:0] addr;
  } access_t;

endpackage

// ---- rtl/spi_command_decoder.sv ----
`timescale 1ns/100ps
// Summary of operation
// [R1] a frame opens on chip-select fall, closes on rise; frames are independent
// [R2] first eight serial input bits after chip-select fall form the command
// [R3] command splits into device address, register/quick code, command type
// [R4] status byte shifts out on serial output while the command shifts in
// [R5] command runs only when its top two bits equal the fixed address
// [R6] address mismatch releases the serial output; host must end the frame
// [R7] middle four bits: start register for accesses, code for quick commands
// [R8] write starting at a read-only register is refused, not executed
// [R9] reads are accepted at all sixteen addresses
// [R10] type 01 static read, 10 incremental write, 11 incremental read, 00 quick
// [R11] command type stays fixed until chip-select rises
// [R12] quick code 1010 sets conversion mode to 11, starting or restarting
// [R13] quick code 1011 sets conversion mode to 10, standby
// [R14] quick code 1100 sets conversion mode to 00, shutdown
// [R15] quick code 1101 writes zero to the whole first configuration register
// [R16] quick code 1110 resets the whole device to default values
// [R17] undefined quick codes are ignored
// [R18] quick command runs after its byte; output stays released until frame ends
// [R19] quick commands run only while the quick command enable is set
// [R20] power-on flag set by full reset command, cleared by power-on reset
// [R21] only full reset or power-on reset clears conversion data
// [R22] write data flows in on serial input, read data out on serial output
// [R23] input sampled on rising link clock edge, output changed on falling
// [R24] first two status bits driven zero right after chip-select falls
module spi_command_decoder (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic quick_command_enable,
  input wire logic data_ready_status,
  input wire logic crc_error_status,
  input wire logic spi_sck,
  input wire logic cs_b,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  output logic [7:0] first_config_register,
  output logic power_on_flag,
  output logic conv_restart,
  output logic full_reset,
  output logic data_clear,
  output logic status_ack,
  output spi_cmd_pkg::access_t access,
  output logic write_refused
);

  // ----------------------------------------------------------------
  // reset for the link side
  // ----------------------------------------------------------------
  logic link_rst_q;
  logic frame_rst;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link_rst_q <= 1'b1;
    end else begin
      link_rst_q <= 1'b0;
    end
  end

  // cs high clears the whole frame state
  assign frame_rst = cs_b | link_rst_q; // [R1]

  // ----------------------------------------------------------------
  // status sources held in clk domain
  // ----------------------------------------------------------------
  spi_cmd_pkg::status_t stat_src_q;
  logic por_flag_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stat_src_q <= '0;
    end else begin
      stat_src_q <= '{data_ready: data_ready_status,
                      crc_error: crc_error_status,
                      power_on: por_flag_q};
    end
  end

  // ----------------------------------------------------------------
  // link side: command shifting
  // ----------------------------------------------------------------
  logic [3:0] cnt_q;
  logic [6:0] shift_q;
  logic match_q;
  spi_cmd_pkg::status_t stat_s1_q;
  spi_cmd_pkg::status_t stat_s2_q;
  spi_cmd_pkg::status_t stat_lat_q;

  always_ff @(posedge spi_sck or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_q <= 4'h0;
      shift_q <= 7'h00;
      match_q <= 1'b0;
      stat_s1_q <= '0;
      stat_s2_q <= '0;
      stat_lat_q <= '0;
    end else begin
      if (cnt_q != spi_cmd_pkg::CMD_DONE) begin
        cnt_q <= cnt_q + 4'h1;
      end
      shift_q <= {shift_q[5:0], sdi}; // [R2] [R23]
      if (cnt_q == spi_cmd_pkg::ADDR_DONE) begin
        match_q <= ({shift_q[0], sdi} == spi_cmd_pkg::DEV_ADDR); // [R5]
      end
      stat_s1_q <= stat_src_q;
      stat_s2_q <= stat_s1_q;
      if (cnt_q == spi_cmd_pkg::STAT_LATCH) begin
        stat_lat_q <= stat_s2_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // link side: command hand-off, survives cs rise
  // ----------------------------------------------------------------
  spi_cmd_pkg::cmd_t cmd_q;
  logic evt_tgl_q;

  always_ff @(posedge spi_sck or posedge link_rst_q) begin
    if (link_rst_q) begin
      cmd_q <= '0;
      evt_tgl_q <= 1'b0;
    end else if (cnt_q == spi_cmd_pkg::CMD_LAST_BIT && match_q) begin
      cmd_q <= spi_cmd_pkg::cmd_t'({shift_q, sdi}); // [R3] [R5]
      evt_tgl_q <= ~evt_tgl_q;
    end
  end

  // ----------------------------------------------------------------
  // link side: serial output on falling edge
  // ----------------------------------------------------------------
  logic sdo_q;
  logic drive_q;
  logic [7:0] stat_byte;

  assign stat_byte = {2'b00, spi_cmd_pkg::DEV_ADDR,
                      ~spi_cmd_pkg::DEV_ADDR[0], stat_lat_q}; // [R4]

  always_ff @(negedge spi_sck or posedge frame_rst) begin
    if (frame_rst) begin
      sdo_q <= 1'b0; // [R24]
      drive_q <= 1'b1;
    end else begin
      if (cnt_q == spi_cmd_pkg::STAT_LATCH && !match_q) begin
        drive_q <= 1'b0; // [R6]
      end
      if (cnt_q != 4'h0 && cnt_q != spi_cmd_pkg::CMD_DONE) begin
        sdo_q <= stat_byte[~cnt_q[2:0]]; // [R4] [R23]
      end
      if (cnt_q == spi_cmd_pkg::CMD_DONE) begin
        sdo_q <= 1'b0;
        if (!cmd_q.ctype[0]) begin
          drive_q <= 1'b0; // [R18] [R22]
        end
      end
    end
  end

  assign sdo = sdo_q;
  // released at once when cs rises
  assign sdo_oe = drive_q & ~cs_b; // [R1]

  // ----------------------------------------------------------------
  // clk side: command event crossing
  // ----------------------------------------------------------------
  logic evt_s1_q;
  logic evt_s2_q;
  logic evt_s3_q;
  logic evt;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      evt_s1_q <= 1'b0;
      evt_s2_q <= 1'b0;
      evt_s3_q <= 1'b0;
    end else begin
      evt_s1_q <= evt_tgl_q;
      evt_s2_q <= evt_s1_q;
      evt_s3_q <= evt_s2_q;
    end
  end

  assign evt = evt_s2_q ^ evt_s3_q;

  // ----------------------------------------------------------------
  // clk side: decode
  // ----------------------------------------------------------------
  logic is_quick;
  logic run_quick;
  logic ro_target;

  assign is_quick = cmd_q.ctype == spi_cmd_pkg::CT_QUICK; // [R10]
  assign run_quick = evt && is_quick && quick_command_enable; // [R19]
  assign ro_target = spi_cmd_pkg::READ_ONLY_MASK[cmd_q.reg_addr]; // [R8]

  // one command per frame, so the type is fixed for the frame
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      access <= '0;
      write_refused <= 1'b0;
      status_ack <= 1'b0;
    end else begin
      access <= '0;
      write_refused <= 1'b0;
      status_ack <= evt; // [R4]
      if (evt && !is_quick) begin // [R11]
        unique case (cmd_q.ctype)
          spi_cmd_pkg::CT_STATIC_READ: begin
            access <= '{valid: 1'b1, read: 1'b1, incremental: 1'b0,
                        addr: cmd_q.reg_addr}; // [R7] [R9] [R10]
          end
          spi_cmd_pkg::CT_INCR_READ: begin
            access <= '{valid: 1'b1, read: 1'b1, incremental: 1'b1,
                        addr: cmd_q.reg_addr}; // [R9] [R10]
          end
          spi_cmd_pkg::CT_INCR_WRITE: begin
            if (ro_target) begin
              write_refused <= 1'b1; // [R8]
            end else begin
              access <= '{valid: 1'b1, read: 1'b0, incremental: 1'b1,
                          addr: cmd_q.reg_addr}; // [R7] [R10] [R22]
            end
          end
          spi_cmd_pkg::CT_QUICK: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // clk side: quick commands
  // ----------------------------------------------------------------
  logic [7:0] cfg0_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg0_q <= spi_cmd_pkg::CFG0_RESET;
      conv_restart <= 1'b0;
      full_reset <= 1'b0;
      data_clear <= 1'b0;
    end else begin
      conv_restart <= 1'b0;
      full_reset <= 1'b0;
      data_clear <= 1'b0;
      if (run_quick) begin // [R18]
        unique case (cmd_q.reg_addr) // [R7]
          spi_cmd_pkg::QC_CONV_START: begin
            cfg0_q[spi_cmd_pkg::MODE_LSB +: 2] <=
              spi_cmd_pkg::MODE_CONVERT; // [R12]
            conv_restart <= 1'b1; // [R12]
          end
          spi_cmd_pkg::QC_STANDBY: begin
            cfg0_q[spi_cmd_pkg::MODE_LSB +: 2] <=
              spi_cmd_pkg::MODE_STANDBY; // [R13]
          end
          spi_cmd_pkg::QC_SHUTDOWN: begin
            cfg0_q[spi_cmd_pkg::MODE_LSB +: 2] <=
              spi_cmd_pkg::MODE_SHUTDOWN; // [R14]
          end
          spi_cmd_pkg::QC_FULL_SHUTDOWN: begin
            cfg0_q <= spi_cmd_pkg::CFG0_FULL_SHUTDOWN; // [R15]
          end
          spi_cmd_pkg::QC_FULL_RESET: begin
            cfg0_q <= spi_cmd_pkg::CFG0_RESET; // [R16]
            full_reset <= 1'b1; // [R16]
            data_clear <= 1'b1; // [R21]
          end
          default: begin
          end // [R17]
        endcase
      end
    end
  end

  // power-on flag
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      por_flag_q <= 1'b0; // [R20]
    end else if (run_quick &&
                 cmd_q.reg_addr == spi_cmd_pkg::QC_FULL_RESET) begin
      por_flag_q <= 1'b1; // [R20]
    end
  end

  assign first_config_register = cfg0_q;
  assign power_on_flag = por_flag_q;

endmodule

// ---- verification/spi_command_decoder_monitor.sv ----
`timescale 1ns/100ps
module spi_command_decoder_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic quick_command_enable,
  input wire logic data_ready_status,
  input wire logic crc_error_status,
  input wire logic spi_sck,
  input wire logic cs_b,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic [7:0] first_config_register,
  input wire logic power_on_flag,
  input wire logic conv_restart,
  input wire logic full_reset,
  input wire logic data_clear,
  input wire logic status_ack,
  input wire spi_cmd_pkg::access_t access,
  input wire logic write_refused
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_restart_mode;
    conv_restart |->
      ##[0:2] first_config_register[1:0] == spi_cmd_pkg::MODE_CONVERT;
  endproperty
  a_restart_mode: assert property (p_restart_mode)
    else $error("restart without convert mode");

  property p_restart_gated;
    conv_restart |-> $past(quick_command_enable, 2);
  endproperty
  a_restart_gated: assert property (p_restart_gated)
    else $error("restart while quick commands disabled");

  property p_cfg_gated;
    $changed(first_config_register) |-> $past(quick_command_enable, 2);
  endproperty
  a_cfg_gated: assert property (p_cfg_gated)
    else $error("config changed while quick commands disabled");

  property p_clear_pair;
    (full_reset || data_clear) |-> (full_reset && data_clear);
  endproperty
  a_clear_pair: assert property (p_clear_pair)
    else $error("data clear not paired with full reset");

  property p_reset_defaults;
    full_reset |-> ##[0:2] (power_on_flag &&
      first_config_register == spi_cmd_pkg::CFG0_RESET);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("full reset left wrong defaults");

  property p_refused_quiet;
    write_refused |-> !access.valid && !conv_restart;
  endproperty
  a_refused_quiet: assert property (p_refused_quiet)
    else $error("refused write still executed");

  property p_released_idle;
    cs_b |-> !sdo_oe && !sdo;
  endproperty
  a_released_idle: assert property (p_released_idle)
    else $error("serial output driven outside frame");

  property p_one_cmd;
    (access.valid || write_refused) |=>
      !(access.valid || write_refused) [*8];
  endproperty
  a_one_cmd: assert property (p_one_cmd)
    else $error("more than one command decoded");
endmodule

bind spi_command_decoder spi_command_decoder_monitor i_mon (.*);

// ---- verification/spi_host_model.sv ----
`timescale 1ns/100ps
module spi_host_model (
  output logic spi_sck,
  output logic cs_b,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  initial begin
    spi_sck = 1'b0;
    cs_b = 1'b1;
    sdi = 1'b0;
  end

  // one framed command, mode 0,0, clock stands still outside frames
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] stat,
                      output logic oe);
    cs_b = 1'b0;
    #6;
    for (int i = 7; i >= 0; i--) begin
      sdi = cmd[i];
      #6;
      spi_sck = 1'b1;
      stat[i] = sdo;
      #6;
      spi_sck = 1'b0;
    end
    sdi = ~cmd[0];
    #6;
    oe = sdo_oe;
    cs_b = 1'b1;
    #6;
  endtask
endmodule

// ---- verification/spi_command_decoder_bench.sv ----
`timescale 1ns/100ps
module spi_command_decoder_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic qc_en = 1'b0;
  logic dr = 1'b1;
  logic crc = 1'b0;
  wire logic sck, cs_b, sdi, sdo, oe;
  logic [7:0] cfg, stat;
  logic por, rs, fr, dc, ack, rf, oe_end, ro;
  spi_cmd_pkg::access_t acc, last;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int cnt [6];
  logic [3:0] qc [9] = '{4'hb, 4'h0, 4'h8, 4'h9, 4'hf, 4'hc, 4'ha, 4'hd, 4'he};
  logic [7:0] qv [9] = '{8'h12, 8'h12, 8'h12, 8'h12, 8'h12, 8'h10, 8'h13,
                         8'h00, 8'h10};
  logic [5:0] ac [5] = '{6'h01, 6'h3f, 6'h16, 6'h02, 6'h3e};
  wire logic [5:0] pl = {rs, fr, dc, ack, rf, acc.valid};
  wire logic [7:0] st_e = {2'b00, spi_cmd_pkg::DEV_ADDR,
                           ~spi_cmd_pkg::DEV_ADDR[0], dr, crc, 1'b0};

  always #5 clk = ~clk;

  spi_command_decoder i_dut (.clk(clk), .rst_b(rst_b),
    .quick_command_enable(qc_en), .data_ready_status(dr),
    .crc_error_status(crc), .spi_sck(sck), .cs_b(cs_b), .sdi(sdi),
    .sdo(sdo), .sdo_oe(oe), .first_config_register(cfg),
    .power_on_flag(por), .conv_restart(rs), .full_reset(fr),
    .data_clear(dc), .status_ack(ack), .access(acc),
    .write_refused(rf));

  spi_host_model i_host (.spi_sck(sck), .cs_b(cs_b), .sdi(sdi),
    .sdo(sdo), .sdo_oe(oe));

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (acc.valid === 1'b1) last = acc;
    foreach (cnt[k]) cnt[k] += int'(pl[k] === 1'b1);
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic cmp(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic frame(input logic [7:0] cmd);
    @(negedge clk);
    cnt = '{default: 0};
    last = '0;
    i_host.xfer(cmd, stat, oe_end);
    repeat (10) @(negedge clk);
  endtask

  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    cmp("cfg0", spi_cmd_pkg::CFG0_RESET, cfg);
    cmp("por", 8'h00, {7'h0, por});
    frame({2'h2, spi_cmd_pkg::QC_CONV_START, 2'b00});
    cmp("stat_hi", 8'h00, {6'h0, stat[7:6]});
    cmp("pulses", 8'h00, 8'(cnt.sum()));
    cmp("oe", 8'h00, {7'h0, oe_end});
    frame({spi_cmd_pkg::DEV_ADDR, spi_cmd_pkg::QC_STANDBY, 2'b00});
    cmp("cfg0", 8'h10, cfg);
    cmp("ack", 8'h01, 8'(cnt[2]));
    qc_en = 1'b1;
    for (int k = 0; k < 9; k++) begin
      frame({spi_cmd_pkg::DEV_ADDR, qc[k], 2'b00});
      cmp("status", st_e, {stat[7:1], 1'b0});
      cmp("cfg0", qv[k], cfg);
      cmp("restart", 8'(qc[k] == spi_cmd_pkg::QC_CONV_START), 8'(cnt[5]));
      cmp("reset", 8'(qc[k] == spi_cmd_pkg::QC_FULL_RESET ? 2 : 0),
          8'(cnt[4] + cnt[3]));
      cmp("oe", 8'h00, {7'h0, oe_end});
    end
    cmp("por", 8'h01, {7'h0, por});
    dr = 1'b0;
    crc = 1'b1;
    for (int k = 0; k < 5; k++) begin
      ro = ac[k][1:0] == 2'b10 && spi_cmd_pkg::READ_ONLY_MASK[ac[k][5:2]];
      frame({spi_cmd_pkg::DEV_ADDR, ac[k]});
      cmp("status", st_e, {stat[7:1], 1'b0});
      cmp("access", ro ? 8'h00 : {2'b01, ac[k][0], ac[k][1], ac[k][5:2]},
          {1'b0, last});
      cmp("refused", {7'h0, ro}, 8'(cnt[1]));
      cmp("oe", {7'h0, ac[k][0]}, {7'h0, oe_end});
    end
    rst_b = 1'b0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    cmp("por", 8'h00, {7'h0, por});
    print_verdict();
  end
endmodule
